// file: sbp_defines.svh
// constants of the self-programming flash controller
`ifndef SBP_DEFINES_SVH
`define SBP_DEFINES_SVH
// timing
`define SBP_CLK_MHZ       250
`define SBP_PROG_TIME_US  4000
`define SBP_PROG_CYC      (`SBP_PROG_TIME_US * `SBP_CLK_MHZ)
`define SBP_TMR_W         20
// flash geometry, word addresses
`define SBP_ADDR_W        14
`define SBP_HALT_BASE     14'h3800
`define SBP_BOOT_BASE0    14'h3800
`define SBP_BOOT_BASE1    14'h3c00
`define SBP_BOOT_BASE2    14'h3e00
`define SBP_BOOT_BASE3    14'h3f00
// register byte offsets
`define SBP_A_STATUS      8'h00
`define SBP_A_CTRL        8'h04
`define SBP_A_IRQ_STAT    8'h08
`define SBP_A_IRQ_MASK    8'h0c
`define SBP_A_LOCK        8'h10
// field positions
`define SBP_ST_BUSY       0
`define SBP_ST_ACTIVE     1
`define SBP_ST_STALL      2
`define SBP_CT_BUSY_CLR   0
`define SBP_IRQ_DONE      0
`define SBP_IRQ_REFUSED   1
`define SBP_LK_WR_BLOCK   0
`define SBP_LK_LD_BLOCK   1
// reset values
`define SBP_LOCK_RST      2'h3
`define SBP_MASK_RST      2'h0
`endif

// file: sbp_pkg.sv
// types of the self-programming flash controller
`default_nettype none
package sbp_pkg;
   typedef enum logic [1:0] {SBP_OP_ERASE, SBP_OP_WRITE, SBP_OP_LOCK, SBP_OP_NONE} sbp_op_e;
   typedef enum logic {SBP_IDLE, SBP_BUSY} sbp_state_e;
endpackage
`default_nettype wire

// file: sbp_op_if.sv
// start and completion of one timed flash operation
`timescale 1ns/1ns
`default_nettype none
interface sbp_op_if;
   logic start;
   logic active;
   logic done;
   modport ctrl (output start, input active, input done);
   modport tmr  (input start, output active, output done);
endinterface
`default_nettype wire

// file: sbp_flag.sv
// sticky flag whose set wins over its clear
`timescale 1ns/1ns
`default_nettype none
module sbp_flag (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic srst,
   // control
   input  wire logic set,
   input  wire logic clr,
   // state
   output logic      q
);
   // set has priority so an event in the clear cycle is kept
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         q <= 1'b0;
      end else if (set) begin
         q <= 1'b1;
      end else if (clr) begin
         q <= 1'b0;
      end
   end
endmodule // sbp_flag
`default_nettype wire

// file: sbp_timer.sv
// counts the duration of a page erase or page write
`timescale 1ns/1ns
`include "sbp_defines.svh"
`default_nettype none
module sbp_timer #(
   parameter int unsigned CYC = `SBP_PROG_CYC
) (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic srst,
   // operation handshake
   sbp_op_if.tmr     op
);
   logic [`SBP_TMR_W-1:0] cnt_reg;
   logic                  act_reg;
   logic                  done_reg;

   // run for CYC cycles after start, then pulse done once
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cnt_reg  <= '0;
         act_reg  <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (op.start && !act_reg) begin
            cnt_reg <= `SBP_TMR_W'(CYC - 1);
            act_reg <= 1'b1;
         end else if (act_reg) begin
            if (cnt_reg == '0) begin
               act_reg  <= 1'b0;
               done_reg <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg - `SBP_TMR_W'(1);
            end
         end
      end
   end

   assign op.active = act_reg;
   assign op.done   = done_reg;
endmodule // sbp_timer
`default_nettype wire

// file: sbp_ctrl.sv
// self-programming flash controller: section decode, locks, stall and busy flag
//
// What this block does
// - store_program_instruction fetched from the application section is ignored.
// - erase or write starts only when issued from boot_loader_section code.
// - from the boot_loader_section any page of the whole flash may be targeted.
// - stall or run decided only by target page address, not execution address.
// - concurrent_read_section target: CPU keeps running, halting_section readable.
// - halting_section target: CPU stalled for the whole erase or write.
// - concurrent_read_section reads are invalid during self-programming.
// - concurrent_read_section is blocked while section_busy_flag reads one.
// - boot_loader_section always lies wholly inside the halting_section.
// - boot_size_fuses set the boot boundary; halting boundary is fixed.
// - two independent lock sets for application and boot_loader_section.
// - application protection comes only from application_lock_set.
// - boot protection comes only from boot_section_lock_set.
// - lock bits are programmed by software; only chip erase clears them (here srst also restores them to 11).
// - lock field 11 free, 10 no write, 00 no write or load, 01 no load.
// - target page address is latched when an operation starts.
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "sbp_defines.svh"
`default_nettype none
module sbp_ctrl #(
   parameter int unsigned PROG_CYC = `SBP_PROG_CYC
) (
   // clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   srst,
   // apb slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [7:0]             paddr,
   input  wire logic [31:0]            pwdata,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr,
   // store program requests from the cpu core
   input  wire logic                   spm_valid,
   input  wire sbp_pkg::sbp_op_e       spm_op,
   input  wire logic [`SBP_ADDR_W-1:0] spm_pc,
   input  wire logic [`SBP_ADDR_W-1:0] spm_addr,
   input  wire logic [3:0]             spm_lock_data,
   // cpu fetches and program memory loads
   input  wire logic [`SBP_ADDR_W-1:0] fetch_addr,
   output logic                        fetch_invalid,
   input  wire logic [`SBP_ADDR_W-1:0] load_pc,
   input  wire logic [`SBP_ADDR_W-1:0] load_addr,
   output logic                        load_invalid,
   output logic                        cpu_stall,
   // fuses and external chip erase
   input  wire logic [1:0]             boot_size_fuses,
   input  wire logic                   chip_erase,
   // flash array control
   output logic                        flash_erase,
   output logic                        flash_write,
   output logic [`SBP_ADDR_W-1:0]      flash_page,
   // interrupt
   output logic                        irq
);
   sbp_op_if op ();

   sbp_pkg::sbp_state_e   state_reg;
   logic                  halt_tgt_reg;
   logic                  erase_reg;
   logic                  write_reg;
   logic [`SBP_ADDR_W-1:0] page_reg;
   logic [1:0]            app_lock_reg;
   logic [1:0]            boot_lock_reg;
   logic [1:0]            mask_reg;
   logic [31:0]           rdata_reg;
   logic                  err_reg;
   logic [`SBP_ADDR_W-1:0] boot_base;
   logic                  pc_in_boot;
   logic                  tgt_in_boot;
   logic                  tgt_in_halt;
   logic                  wr_blocked;
   logic                  accept;
   logic                  refuse;
   logic                  start_prog;
   logic                  busy_q;
   logic                  busy_clr;
   logic [1:0]            irq_q;
   logic [1:0]            irq_set;
   logic [1:0]            irq_clr;
   logic                  wr_en;
   logic                  rd_setup;
   logic                  mapped;

   // boot boundary from the fuses, never below the fixed halting boundary
   always_comb begin
      case (boot_size_fuses)
         2'h0:    boot_base = `SBP_BOOT_BASE0;
         2'h1:    boot_base = `SBP_BOOT_BASE1;
         2'h2:    boot_base = `SBP_BOOT_BASE2;
         default: boot_base = `SBP_BOOT_BASE3;
      endcase
      if (boot_base < `SBP_HALT_BASE) begin
         boot_base = `SBP_HALT_BASE;
      end
   end

   // section decode of execution and target addresses
   assign pc_in_boot  = (spm_pc >= boot_base);
   assign tgt_in_boot = (spm_addr >= boot_base);
   assign tgt_in_halt = (spm_addr >= `SBP_HALT_BASE);

   // write protection of the addressed section from its own lock set
   assign wr_blocked = tgt_in_boot ? !boot_lock_reg[`SBP_LK_WR_BLOCK]
                                   : !app_lock_reg[`SBP_LK_WR_BLOCK];

   // a request is taken only when idle and from boot code; erase and write also need the target not write locked
   always_comb begin
      accept = 1'b0;
      if (spm_valid && pc_in_boot && state_reg == sbp_pkg::SBP_IDLE) begin
         case (spm_op)
            sbp_pkg::SBP_OP_ERASE: accept = !wr_blocked;
            sbp_pkg::SBP_OP_WRITE: accept = !wr_blocked;
            sbp_pkg::SBP_OP_LOCK:  accept = 1'b1;
            default:               accept = 1'b0;
         endcase
      end
   end
   assign refuse     = spm_valid && !accept;
   assign start_prog = accept && (spm_op == sbp_pkg::SBP_OP_ERASE
                                  || spm_op == sbp_pkg::SBP_OP_WRITE);
   assign op.start   = start_prog;

   // operation state: idle until started, busy until the timer finishes
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_reg <= sbp_pkg::SBP_IDLE;
      end else begin
         case (state_reg)
            sbp_pkg::SBP_IDLE: begin
               if (start_prog) begin
                  state_reg <= sbp_pkg::SBP_BUSY;
               end
            end
            sbp_pkg::SBP_BUSY: begin
               if (op.done) begin
                  state_reg <= sbp_pkg::SBP_IDLE;
               end
            end
            default: state_reg <= sbp_pkg::SBP_IDLE;
         endcase
      end
   end

   // latch target page and kind of operation at the start
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         page_reg     <= '0;
         halt_tgt_reg <= 1'b0;
         erase_reg    <= 1'b0;
         write_reg    <= 1'b0;
      end else if (start_prog) begin
         page_reg     <= spm_addr;
         halt_tgt_reg <= tgt_in_halt;
         erase_reg    <= (spm_op == sbp_pkg::SBP_OP_ERASE);
         write_reg    <= (spm_op == sbp_pkg::SBP_OP_WRITE);
      end else if (op.done) begin
         erase_reg    <= 1'b0;
         write_reg    <= 1'b0;
      end
   end

   sbp_timer #(
      .CYC (PROG_CYC)
   ) u_timer (
      .ref_clk (ref_clk),
      .srst    (srst),
      .op      (op.tmr)
   );

   // lock sets: software only programs bits, chip erase or srst clears them
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         app_lock_reg  <= `SBP_LOCK_RST;
         boot_lock_reg <= `SBP_LOCK_RST;
      end else if (chip_erase) begin
         app_lock_reg  <= `SBP_LOCK_RST;
         boot_lock_reg <= `SBP_LOCK_RST;
      end else if (accept && spm_op == sbp_pkg::SBP_OP_LOCK) begin
         app_lock_reg  <= app_lock_reg & spm_lock_data[1:0];
         boot_lock_reg <= boot_lock_reg & spm_lock_data[3:2];
      end
   end

   // busy flag: set on a concurrent page start, cleared by software when idle
   assign busy_clr = wr_en && paddr == `SBP_A_CTRL && pwdata[`SBP_CT_BUSY_CLR]
                     && state_reg == sbp_pkg::SBP_IDLE;
   sbp_flag u_busy (
      .ref_clk (ref_clk),
      .srst    (srst),
      .set     (start_prog && !tgt_in_halt),
      .clr     (busy_clr),
      .q       (busy_q)
   );

   // stall only for a halting target, for the whole operation
   assign cpu_stall = (state_reg == sbp_pkg::SBP_BUSY) && halt_tgt_reg;

   // concurrent section reads are not valid while it is blocked
   assign fetch_invalid = (busy_q || state_reg == sbp_pkg::SBP_BUSY)
                          && fetch_addr < `SBP_HALT_BASE;

   // loads: blocked by the busy section or by the cross-section load lock
   always_comb begin
      load_invalid = (busy_q || state_reg == sbp_pkg::SBP_BUSY)
                     && load_addr < `SBP_HALT_BASE;
      if (load_pc >= boot_base && load_addr < boot_base
          && !app_lock_reg[`SBP_LK_LD_BLOCK]) begin
         load_invalid = 1'b1;
      end
      if (load_pc < boot_base && load_addr >= boot_base
          && !boot_lock_reg[`SBP_LK_LD_BLOCK]) begin
         load_invalid = 1'b1;
      end
   end

   // flash array drive from the latched operation
   assign flash_erase = erase_reg;
   assign flash_write = write_reg;
   assign flash_page  = page_reg;

   // interrupt events: completion and refused request
   assign irq_set[`SBP_IRQ_DONE]    = op.done;
   assign irq_set[`SBP_IRQ_REFUSED] = refuse;
   assign irq_clr = (wr_en && paddr == `SBP_A_IRQ_STAT) ? pwdata[1:0] : 2'h0;
   for (genvar i = 0; i < 2; i++) begin : g_irq
      sbp_flag u_flag (
         .ref_clk (ref_clk),
         .srst    (srst),
         .set     (irq_set[i]),
         .clr     (irq_clr[i]),
         .q       (irq_q[i])
      );
   end
   assign irq = |(irq_q & mask_reg);

   // apb decode: writes act at the access edge, reads prepared at setup
   assign wr_en    = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign mapped   = paddr == `SBP_A_STATUS || paddr == `SBP_A_CTRL
                     || paddr == `SBP_A_IRQ_STAT || paddr == `SBP_A_IRQ_MASK
                     || paddr == `SBP_A_LOCK;
   assign pready   = 1'b1;
   assign prdata   = rdata_reg;
   assign pslverr  = err_reg && psel && penable;

   // interrupt mask register
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         mask_reg <= `SBP_MASK_RST;
      end else if (wr_en && paddr == `SBP_A_IRQ_MASK) begin
         mask_reg <= pwdata[1:0];
      end
   end

   // read data and error captured in the setup cycle
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rdata_reg <= 32'h0000_0000;
         err_reg   <= 1'b0;
      end else if (psel && !penable) begin
         err_reg   <= !mapped;
         rdata_reg <= 32'h0000_0000;
         if (rd_setup) begin
            case (paddr)
               `SBP_A_STATUS: begin
                  rdata_reg[`SBP_ST_BUSY]   <= busy_q;
                  rdata_reg[`SBP_ST_ACTIVE] <= (state_reg == sbp_pkg::SBP_BUSY);
                  rdata_reg[`SBP_ST_STALL]  <= cpu_stall;
               end
               `SBP_A_IRQ_STAT: rdata_reg[1:0] <= irq_q;
               `SBP_A_IRQ_MASK: rdata_reg[1:0] <= mask_reg;
               `SBP_A_LOCK:     rdata_reg[3:0] <= {boot_lock_reg, app_lock_reg};
               default:         rdata_reg <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule // sbp_ctrl
`default_nettype wire

// file: sbp_ctrl_sva.sv
// port assertions for the self-programming flash controller
`timescale 1ns/1ns
`include "sbp_defines.svh"
`default_nettype none
module sbp_ctrl_sva (
   // clock and reset
   input wire logic                   ref_clk,
   input wire logic                   srst,
   // requests, fetches and fuses
   input wire logic                   spm_valid,
   input wire logic [`SBP_ADDR_W-1:0] spm_pc,
   input wire logic [`SBP_ADDR_W-1:0] spm_addr,
   input wire logic [`SBP_ADDR_W-1:0] fetch_addr,
   input wire logic [1:0]             boot_size_fuses,
   // observed outputs
   input wire logic                   fetch_invalid,
   input wire logic                   cpu_stall,
   input wire logic                   flash_erase,
   input wire logic                   flash_write,
   input wire logic [`SBP_ADDR_W-1:0] flash_page
);
   logic [`SBP_ADDR_W-1:0] boot_base;
   logic                   op_on;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   // boot section start as the fuses place it
   always_comb begin
      case (boot_size_fuses)
         2'h0: boot_base = `SBP_BOOT_BASE0;
         2'h1: boot_base = `SBP_BOOT_BASE1;
         2'h2: boot_base = `SBP_BOOT_BASE2;
         default: boot_base = `SBP_BOOT_BASE3;
      endcase
   end
   assign op_on = flash_erase | flash_write;
   stall_halt_a: assert property (op_on && flash_page >= `SBP_HALT_BASE |-> cpu_stall)
      else $error("no stall on halting page");
   run_conc_a: assert property (op_on && flash_page < `SBP_HALT_BASE |-> !cpu_stall)
      else $error("stall on concurrent page");
   app_ignore_a: assert property (spm_valid && spm_pc < boot_base && !op_on |=> !op_on)
      else $error("op started from application");
   boot_start_a: assert property ($rose(op_on) |-> $past(spm_valid) &&
      $past(spm_pc) >= $past(boot_base)) else $error("op start without boot request");
   page_latch_a: assert property ($rose(op_on) |-> flash_page == $past(spm_addr))
      else $error("page not latched");
   page_hold_a: assert property (op_on && $past(op_on) |-> $stable(flash_page))
      else $error("page moved during op");
   fetch_block_a: assert property (op_on && fetch_addr < `SBP_HALT_BASE |-> fetch_invalid)
      else $error("concurrent fetch not blocked");
   halt_read_a: assert property (op_on && fetch_addr >= `SBP_HALT_BASE |-> !fetch_invalid)
      else $error("halting fetch blocked");
   stall_span_a: assert property ($rose(cpu_stall) |-> cpu_stall[*8])
      else $error("stall too short");
   // main scenarios
   conc_op_c: cover property ($rose(op_on) && !cpu_stall);
   halt_op_c: cover property ($rose(op_on) && cpu_stall);
   app_try_c: cover property (spm_valid && spm_pc < boot_base);
endmodule // sbp_ctrl_sva
bind sbp_ctrl sbp_ctrl_sva i_sbp_ctrl_sva (.*);
`default_nettype wire

// file: sbp_cpu_model.sv
// behavioural cpu core issuing store program requests
`timescale 1ns/1ns
`include "sbp_defines.svh"
`default_nettype none
module sbp_cpu_model (
   // clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   srst,
   // commands from the bench
   input  wire logic                   go,
   input  wire sbp_pkg::sbp_op_e       op,
   input  wire logic [`SBP_ADDR_W-1:0] pc,
   input  wire logic [`SBP_ADDR_W-1:0] addr,
   input  wire logic [3:0]             lock_data,
   // request to the controller
   output var logic                    spm_valid = 1'b0,
   output var sbp_pkg::sbp_op_e        spm_op = sbp_pkg::SBP_OP_NONE,
   output var logic [`SBP_ADDR_W-1:0]  spm_pc = 14'h0000,
   output var logic [`SBP_ADDR_W-1:0]  spm_addr = 14'h0000,
   output var logic [3:0]              spm_lock_data = 4'hf
);
   // one-cycle request; the pointer is reused right after it
   always @(posedge ref_clk) begin
      spm_valid <= go & ~srst;
      if (go) begin
         spm_op <= op;
         spm_pc <= pc;
         spm_addr <= addr;
         spm_lock_data <= lock_data;
      end else if (spm_valid) begin
         spm_addr <= ~spm_addr;
      end
   end
endmodule // sbp_cpu_model
`default_nettype wire

// file: boot_self_program_flash_ctrl_test.sv
// testbench of the self-programming flash controller
`timescale 1ns/1ns
`include "sbp_defines.svh"
`default_nettype none
module boot_self_program_flash_ctrl_test;
   logic             ref_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic             chip_erase = 1'b0, go = 1'b0, pready, pslverr, spm_valid, err;
   logic             fetch_invalid, load_invalid, cpu_stall, flash_erase, flash_write, irq;
   logic [1:0]       boot_size_fuses = 2'h0;
   logic [3:0]       g_data = 4'hf, spm_lock_data;
   logic [7:0]       paddr = 8'h00;
   logic [31:0]      pwdata = 32'h0, prdata, rd_data;
   logic [13:0]      fetch_addr = 14'h3f80, load_pc = 14'h3f80, load_addr = 14'h3f80;
   logic [13:0]      g_pc = 14'h0, g_addr = 14'h0, spm_pc, spm_addr, flash_page;
   sbp_pkg::sbp_op_e g_op = sbp_pkg::SBP_OP_NONE, spm_op;
   int               failures = 0, n_tests = 0;
   // clock
   always #2 ref_clk = ~ref_clk;
   // cpu core model and controller with a short program time
   sbp_cpu_model i_sbp_cpu_model (.ref_clk(ref_clk), .srst(srst), .go(go), .op(g_op),
      .pc(g_pc), .addr(g_addr), .lock_data(g_data), .spm_valid(spm_valid), .spm_op(spm_op),
      .spm_pc(spm_pc), .spm_addr(spm_addr), .spm_lock_data(spm_lock_data));
   sbp_ctrl #(.PROG_CYC(40)) i_sbp_ctrl (.ref_clk(ref_clk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .spm_valid(spm_valid), .spm_op(spm_op),
      .spm_pc(spm_pc), .spm_addr(spm_addr), .spm_lock_data(spm_lock_data),
      .fetch_addr(fetch_addr), .fetch_invalid(fetch_invalid), .load_pc(load_pc),
      .load_addr(load_addr), .load_invalid(load_invalid), .cpu_stall(cpu_stall),
      .boot_size_fuses(boot_size_fuses), .chip_erase(chip_erase), .flash_erase(flash_erase),
      .flash_write(flash_write), .flash_page(flash_page), .irq(irq));
   task report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // hold the access phase until the slave answers; only the watchdog ends a hang
      @(posedge ref_clk);
      while (pready !== 1'b1) begin
         @(posedge ref_clk);
      end
      rd_data = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd_data);
   endtask
   task store_program_instruction(input sbp_pkg::sbp_op_e o, input logic [13:0] pc, a, input logic [3:0] d);
      @(posedge ref_clk);
      go <= 1'b1;
      g_op <= o;
      g_pc <= pc;
      g_addr <= a;
      g_data <= d;
      @(posedge ref_clk);
      go <= 1'b0;
      @(posedge ref_clk);
      #1;
   endtask
   task fchk(input logic [13:0] a, input logic e, input string nm);
      @(posedge ref_clk);
      fetch_addr <= a;
      #1;
      chk(nm, {31'h0, e}, {31'h0, fetch_invalid});
   endtask
   task wdone;
      int n;
      n = 0;
      while ((flash_erase | flash_write) !== 1'b0 && n < 200) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk("op end", 32'h0, {31'h0, flash_erase | flash_write});
   endtask
   task t_reset;
      chk("ready", 32'h1, {31'h0, pready});
      rd(`SBP_A_LOCK, 32'hf, "lock");
      rd(`SBP_A_IRQ_MASK, 32'h0, "mask");
      rd(`SBP_A_STATUS, 32'h0, "status");
      rd(8'h14, 32'h0, "unmapped");
      chk("unmapped err", 32'h1, {31'h0, err});
      $display("reset test done");
   endtask
   task t_refuse;
      store_program_instruction(sbp_pkg::SBP_OP_ERASE, 14'h0100, 14'h0200, 4'hf);
      chk("app erase", 32'h0, {31'h0, flash_erase});
      @(posedge ref_clk);
      boot_size_fuses <= 2'h2;
      store_program_instruction(sbp_pkg::SBP_OP_WRITE, 14'h3d00, 14'h3d00, 4'hf);
      chk("mid boot", 32'h0, {31'h0, flash_write});
      @(posedge ref_clk);
      boot_size_fuses <= 2'h3;
      store_program_instruction(sbp_pkg::SBP_OP_WRITE, 14'h3c00, 14'h3c00, 4'hf);
      chk("small boot", 32'h0, {31'h0, flash_write});
      rd(`SBP_A_IRQ_STAT, 32'h2, "refused");
      chk("masked irq", 32'h0, {31'h0, irq});
      apb(1'b1, `SBP_A_IRQ_STAT, 32'h2);
      rd(`SBP_A_IRQ_STAT, 32'h0, "refused clear");
      $display("refuse test done");
   endtask
   task t_rww;
      @(posedge ref_clk);
      boot_size_fuses <= 2'h1;
      apb(1'b1, `SBP_A_IRQ_MASK, 32'h3);
      store_program_instruction(sbp_pkg::SBP_OP_ERASE, 14'h3c00, 14'h0100, 4'hf);
      chk("erase", 32'h1, {31'h0, flash_erase});
      chk("page", 32'h100, {18'h0, flash_page});
      chk("stall", 32'h0, {31'h0, cpu_stall});
      fchk(14'h0200, 1'b1, "conc fetch");
      fchk(14'h3900, 1'b0, "halt fetch");
      fchk(14'h3c00, 1'b0, "boot vector fetch");
      rd(`SBP_A_STATUS, 32'h3, "busy active");
      wdone;
      chk("done irq", 32'h1, {31'h0, irq});
      rd(`SBP_A_STATUS, 32'h1, "busy held");
      fchk(14'h0200, 1'b1, "fetch pre clear");
      apb(1'b1, `SBP_A_CTRL, 32'h1);
      rd(`SBP_A_STATUS, 32'h0, "busy clear");
      fchk(14'h0200, 1'b0, "fetch post clear");
      apb(1'b1, `SBP_A_IRQ_STAT, 32'h1);
      chk("irq clear", 32'h0, {31'h0, irq});
      $display("concurrent test done");
   endtask
   task t_halting_section;
      store_program_instruction(sbp_pkg::SBP_OP_WRITE, 14'h3c00, 14'h3f00, 4'hf);
      chk("boot write", 32'h1, {31'h0, flash_write});
      chk("stall", 32'h1, {31'h0, cpu_stall});
      wdone;
      chk("stall end", 32'h0, {31'h0, cpu_stall});
      rd(`SBP_A_STATUS, 32'h0, "no busy");
      apb(1'b1, `SBP_A_IRQ_STAT, 32'h1);
      $display("halting test done");
   endtask
   task t_lock;
      store_program_instruction(sbp_pkg::SBP_OP_LOCK, 14'h3c00, 14'h0, 4'he);
      rd(`SBP_A_LOCK, 32'he, "app lock");
      store_program_instruction(sbp_pkg::SBP_OP_WRITE, 14'h3c00, 14'h0100, 4'hf);
      chk("app blocked", 32'h0, {31'h0, flash_write});
      store_program_instruction(sbp_pkg::SBP_OP_WRITE, 14'h3c00, 14'h3e00, 4'hf);
      chk("boot open", 32'h1, {31'h0, flash_write});
      wdone;
      store_program_instruction(sbp_pkg::SBP_OP_LOCK, 14'h3c00, 14'h0, 4'h7);
      rd(`SBP_A_LOCK, 32'h6, "boot lock");
      @(posedge ref_clk);
      load_pc <= 14'h0100;
      load_addr <= 14'h3e00;
      #1;
      chk("boot load", 32'h1, {31'h0, load_invalid});
      @(posedge ref_clk);
      chip_erase <= 1'b1;
      @(posedge ref_clk);
      chip_erase <= 1'b0;
      rd(`SBP_A_LOCK, 32'hf, "erased lock");
      chk("load open", 32'h0, {31'h0, load_invalid});
      apb(1'b1, `SBP_A_IRQ_STAT, 32'h3);
      $display("lock test done");
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge ref_clk);
      srst <= 1'b0;
      t_reset;
      t_refuse;
      t_rww;
      t_halting_section;
      t_lock;
      report_and_stop;
   end
   // watchdog
   initial begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      report_and_stop;
   end
endmodule // boot_self_program_flash_ctrl_test
`default_nettype wire
